// File: nbh_dev.sv
`timescale 1ns/1ns
module nbh_dev (
   input wire logic i_ce_n,       // select
   input wire logic i_cle,        // cmd latch
   input wire logic i_ale,        // addr latch
   input wire logic i_we_n,       // write strobe
   input wire logic i_re_n,       // read strobe
   input wire logic i_wp_n,       // protect
   input wire logic [7:0] i_bus,  // bus in
   output logic [7:0] o_bus,      // bus out
   output logic o_rb_n            // ready/busy
);
   logic [9:0] log_q[$];
   logic [7:0] cmd = 8'hff;
   logic [7:0] col = 8'h0;
   logic [7:0] dq = 8'h0;
   logic [2:0] na = 3'h0;
   logic ptr_b = 1'b0;
   logic stat = 1'b0;
   logic prot_err = 1'b0;
   int busy_ns = 300;
   event go_busy;
   initial o_rb_n = 1'b1;
   assign o_bus = (!i_ce_n && !i_re_n && i_we_n && !i_cle && !i_ale) ? dq : ~dq;
   // every accepted byte is logged; no clock, so strobe edges only
   // byte-wide model, 01h honoured
   always @(posedge i_we_n) begin
      if (!i_ce_n && i_re_n && i_cle && !i_ale && (o_rb_n || i_bus inside {8'h70, 8'hff})) begin
         log_q.push_back({2'h1, i_bus});
         na = 3'h0;
         stat = (i_bus == 8'h70);
         ptr_b = (i_bus == 8'h01) ? 1'b1 : ((i_bus inside {8'h00, 8'hff}) ? 1'b0 : ptr_b);
         if ((i_bus inside {8'h80, 8'h60, 8'h10, 8'hd0, 8'h8a}) && !i_wp_n) prot_err = 1'b1;
         else if (i_bus inside {8'h10, 8'hd0, 8'hff}) ->go_busy;
         cmd = i_bus;
      end else if (!i_ce_n && i_re_n && i_ale && !i_cle && na < 3'h4) begin
         log_q.push_back({2'h2, i_bus});
         if (na == 3'h0) col = i_bus;
         na = na + 3'h1;
         if (na == 3'h4 && (cmd inside {8'h00, 8'h01, 8'h50, 8'h8a})) ->go_busy;
      end else if (!i_ce_n && i_re_n && !i_ale && !i_cle) begin
         log_q.push_back({2'h3, i_bus});
      end
   end
   always @(go_busy) begin
      #20 o_rb_n = 1'b0;
      #(busy_ns) o_rb_n = 1'b1;
      ptr_b = 1'b0;
   end
   always @(negedge i_re_n) begin
      if (!i_ce_n) begin
         dq = stat ? 8'hc0 : (col ^ 8'h5a);
         col = col + 8'h1;
      end
   end
endmodule : nbh_dev

// File: nbh_fifo.sv
`timescale 1ns/1ns
module nbh_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic i_mclk,              // system clock
   input wire logic i_sys_rst,           // sync reset, high
   input wire logic i_in_valid,          // word offered
   output logic o_in_ready,              // room for a word
   input wire logic [WIDTH-1:0] i_in_data, // word in
   output logic o_out_valid,             // word available
   input wire logic i_out_ready,         // drain takes word
   output logic [WIDTH-1:0] o_out_data   // oldest word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_valid = (count != '0);
   assign o_out_data = mem[rd_ptr];

   // occupancy after this cycle
   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   // ready is registered so the top sees a flop
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         count <= '0;
         o_in_ready <= 1'b1;
      end else begin
         count <= next_count;
         o_in_ready <= (next_count != DEPTH_C);
      end
   end

   // pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST_C) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST_C) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   // storage
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end
endmodule : nbh_fifo

// File: nbh_host.sv
`timescale 1ns/1ns
module nbh_host #(
   parameter int DATA_W = 8,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic i_mclk,                          // 25 MHz clock
   input wire logic i_sys_rst,                       // sync reset, high
   input wire logic i_req_valid,                     // request offered
   input wire nbh_pkg::nbh_req_t i_req,              // request fields
   output logic o_req_ready,                         // idle, takes request
   output logic o_done,                              // request finished pulse
   input wire logic i_wr_valid,                      // program word offered
   input wire logic [DATA_W-1:0] i_wr_data,          // program word
   output logic o_wr_ready,                          // fifo has room
   output logic o_rd_valid,                          // read word pulse
   output logic [DATA_W-1:0] o_rd_data,              // read word
   output logic o_ce_n,                              // chip select pin
   output logic o_command_latch_en,                  // command latch pin
   output logic o_address_latch_en,                  // address latch pin
   output logic o_we_n,                              // write strobe pin
   output logic o_re_n,                              // read strobe pin
   output logic o_wp_n,                              // write protect pin
   output logic [DATA_W-1:0] o_bus,                  // data pins out
   output logic o_bus_oe,                            // data pins driven
   input wire logic [DATA_W-1:0] i_bus,              // data pins in
   input wire logic i_ready_busy_n                   // ready/busy pin
);
   localparam int LOW_I = (nbh_pkg::T_STB_LOW_NS + nbh_pkg::CLK_NS - 1) / nbh_pkg::CLK_NS;
   localparam int HIGH_I = (nbh_pkg::T_STB_HIGH_NS + nbh_pkg::CLK_NS - 1) / nbh_pkg::CLK_NS;
   localparam int WB_I = (nbh_pkg::T_WB_NS + nbh_pkg::CLK_NS - 1) / nbh_pkg::CLK_NS;
   localparam logic [7:0] LOW_CYC = 8'(LOW_I);
   localparam logic [7:0] CYC_LAST = 8'(LOW_I + HIGH_I - 1);
   // synced pins lag two flops, so sample two cycles after the last low one
   localparam logic [7:0] SAMPLE_AT = 8'(LOW_I + 1);
   localparam logic [7:0] WB_CYC = 8'(WB_I);
   localparam bit X16 = (DATA_W == 16);

   typedef enum {S_IDLE, S_RUN} nbh_state_t;

   nbh_state_t state;
   nbh_pkg::nbh_req_t req;
   nbh_pkg::nbh_act_t act;
   logic [2:0] step;
   logic [1:0] aidx;
   logic [nbh_pkg::LEN_W-1:0] wcnt;
   logic [7:0] cnt;
   logic [DATA_W-1:0] bus_meta;
   logic [DATA_W-1:0] bus_s;
   logic rb_meta;
   logic rb_s;
   logic f_valid;
   logic f_pop;
   logic [DATA_W-1:0] f_data;
   logic active;
   logic cyc_end;
   logic [1:0] abyte;
   logic next_cle;
   logic next_ale;
   logic next_we_n;
   logic next_re_n;
   logic next_oe;
   logic [DATA_W-1:0] next_bus;

   // pointer code for the chosen area
   function automatic logic [7:0] ptr_code(input nbh_pkg::nbh_area_t area);
      if (area == nbh_pkg::AREA_B && !X16) begin
         return nbh_pkg::CMD_READ_B;
      end else if (area == nbh_pkg::AREA_C) begin
         return nbh_pkg::CMD_READ_C;
      end
      return nbh_pkg::CMD_READ_A;
   endfunction : ptr_code

   function automatic nbh_pkg::nbh_act_t mk(input nbh_pkg::nbh_kind_t k, input logic [7:0] c,
                                            input logic [1:0] f, input logic [1:0] l,
                                            input logic d);
      return '{kind: k, code: c, a_first: f, a_last: l, dst: d};
   endfunction : mk

   // sequence table: one action per step of each operation
   function automatic nbh_pkg::nbh_act_t step_act(input nbh_pkg::nbh_req_t r,
                                                  input logic [2:0] s);
      nbh_pkg::nbh_act_t e;
      e = mk(nbh_pkg::K_END, 8'h00, 2'h0, 2'h0, 1'b0);
      case (r.op)
         nbh_pkg::OP_READ: begin
            case (s)
               3'h0: e = mk(nbh_pkg::K_CMD, ptr_code(r.area), 2'h0, 2'h0, 1'b0);
               3'h1: e = mk(nbh_pkg::K_ADDR, 8'h00, nbh_pkg::ABYTE_COL, nbh_pkg::ABYTE_ROW2, 1'b0);
               3'h2: e = mk(nbh_pkg::K_BUSY, 8'h00, 2'h0, 2'h0, 1'b0);
               3'h3: e = mk(nbh_pkg::K_RDATA, 8'h00, 2'h0, 2'h0, 1'b0);
               default: ;
            endcase
         end
         nbh_pkg::OP_PROG: begin
            case (s)
               3'h0: e = mk(nbh_pkg::K_CMD, ptr_code(r.area), 2'h0, 2'h0, 1'b0);
               3'h1: e = mk(nbh_pkg::K_CMD, nbh_pkg::CMD_PROG, 2'h0, 2'h0, 1'b0);
               3'h2: e = mk(nbh_pkg::K_ADDR, 8'h00, nbh_pkg::ABYTE_COL, nbh_pkg::ABYTE_ROW2, 1'b0);
               3'h3: e = mk(nbh_pkg::K_WDATA, 8'h00, 2'h0, 2'h0, 1'b0);
               3'h4: e = mk(nbh_pkg::K_CMD, nbh_pkg::CMD_PROG_GO, 2'h0, 2'h0, 1'b0);
               3'h5: e = mk(nbh_pkg::K_BUSY, 8'h00, 2'h0, 2'h0, 1'b0);
               default: ;
            endcase
         end
         nbh_pkg::OP_ERASE: begin
            case (s)
               3'h0: e = mk(nbh_pkg::K_CMD, nbh_pkg::CMD_ERASE, 2'h0, 2'h0, 1'b0);
               3'h1: e = mk(nbh_pkg::K_ADDR, 8'h00, nbh_pkg::ABYTE_ROW0, nbh_pkg::ABYTE_ROW2, 1'b0);
               3'h2: e = mk(nbh_pkg::K_CMD, nbh_pkg::CMD_ERASE_GO, 2'h0, 2'h0, 1'b0);
               3'h3: e = mk(nbh_pkg::K_BUSY, 8'h00, 2'h0, 2'h0, 1'b0);
               default: ;
            endcase
         end
         // copy-back sent without the optional confirm
         nbh_pkg::OP_COPY: begin
            case (s)
               3'h0: e = mk(nbh_pkg::K_CMD, nbh_pkg::CMD_READ_A, 2'h0, 2'h0, 1'b0);
               3'h1: e = mk(nbh_pkg::K_ADDR, 8'h00, nbh_pkg::ABYTE_COL, nbh_pkg::ABYTE_ROW2, 1'b0);
               3'h2: e = mk(nbh_pkg::K_BUSY, 8'h00, 2'h0, 2'h0, 1'b0);
               3'h3: e = mk(nbh_pkg::K_CMD, nbh_pkg::CMD_COPY, 2'h0, 2'h0, 1'b0);
               3'h4: e = mk(nbh_pkg::K_ADDR, 8'h00, nbh_pkg::ABYTE_COL, nbh_pkg::ABYTE_ROW2, 1'b1);
               3'h5: e = mk(nbh_pkg::K_BUSY, 8'h00, 2'h0, 2'h0, 1'b0);
               default: ;
            endcase
         end
         nbh_pkg::OP_STATUS: begin
            case (s)
               3'h0: e = mk(nbh_pkg::K_CMD, nbh_pkg::CMD_STATUS, 2'h0, 2'h0, 1'b0);
               3'h1: e = mk(nbh_pkg::K_RDATA, 8'h00, 2'h0, 2'h0, 1'b0);
               default: ;
            endcase
         end
         // reset returns memory pointer to first half
         nbh_pkg::OP_RESET: begin
            case (s)
               3'h0: e = mk(nbh_pkg::K_CMD, nbh_pkg::CMD_RESET, 2'h0, 2'h0, 1'b0);
               3'h1: e = mk(nbh_pkg::K_BUSY, 8'h00, 2'h0, 2'h0, 1'b0);
               default: ;
            endcase
         end
         nbh_pkg::OP_SIG: begin
            case (s)
               3'h0: e = mk(nbh_pkg::K_CMD, nbh_pkg::CMD_SIG, 2'h0, 2'h0, 1'b0);
               3'h1: e = mk(nbh_pkg::K_ADDR, 8'h00, nbh_pkg::ABYTE_COL, nbh_pkg::ABYTE_COL, 1'b0);
               3'h2: e = mk(nbh_pkg::K_RDATA, 8'h00, 2'h0, 2'h0, 1'b0);
               default: ;
            endcase
         end
         default: ;
      endcase
      return e;
   endfunction : step_act

   // address byte by index; row bit 0 is A9
   function automatic logic [7:0] addr_byte(input nbh_pkg::nbh_req_t r, input logic [1:0] i,
                                            input logic d);
      logic [nbh_pkg::ROW_W-1:0] row;
      row = d ? r.dst_row : r.row;
      case (i)
         nbh_pkg::ABYTE_COL: return r.col;
         nbh_pkg::ABYTE_ROW0: return row[7:0];
         nbh_pkg::ABYTE_ROW1: return row[15:8];
         // upper lines of last cycle low
         default: return 8'({row[nbh_pkg::ROW_W-1:nbh_pkg::ROW_TOP_LSB]});
      endcase
   endfunction : addr_byte

   nbh_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(i_wr_valid),
      .o_in_ready(o_wr_ready),
      .i_in_data(i_wr_data),
      .o_out_valid(f_valid),
      .i_out_ready(f_pop),
      .o_out_data(f_data)
   );

   // pins from the memory cross into our clock through two flops
   always_ff @(posedge i_mclk) begin
      bus_meta <= i_bus;
      bus_s <= bus_meta;
      rb_meta <= i_ready_busy_n;
      rb_s <= rb_meta;
   end

   assign act = step_act(req, step);
   assign abyte = act.a_first + aidx;
   assign cyc_end = (cnt == CYC_LAST);
   // a write-data cycle waits at its start until the fifo has a word
   assign active = (state == S_RUN) && (act.kind != nbh_pkg::K_BUSY) &&
                   (act.kind != nbh_pkg::K_END) &&
                   !(act.kind == nbh_pkg::K_WDATA && cnt == 8'h00 && !f_valid);
   assign f_pop = active && act.kind == nbh_pkg::K_WDATA && cnt == 8'h00;

   // pin levels for the next cycle
   always_comb begin
      next_cle = 1'b0;
      next_ale = 1'b0;
      next_we_n = 1'b1;
      next_re_n = 1'b1;
      next_oe = 1'b0;
      next_bus = o_bus;
      if (active) begin
         case (act.kind)
            nbh_pkg::K_CMD: begin
               next_cle = 1'b1;
               next_we_n = (cnt >= LOW_CYC);
               next_oe = 1'b1;
               next_bus = DATA_W'(act.code);
            end
            nbh_pkg::K_ADDR: begin
               next_ale = 1'b1;
               next_we_n = (cnt >= LOW_CYC);
               next_oe = 1'b1;
               next_bus = DATA_W'(addr_byte(req, abyte, act.dst));
            end
            nbh_pkg::K_WDATA: begin
               next_we_n = (cnt >= LOW_CYC);
               next_oe = 1'b1;
               if (cnt == 8'h00) begin
                  next_bus = f_data;
               end
            end
            // read strobe, write strobe high, bus released
            nbh_pkg::K_RDATA: begin
               next_re_n = (cnt >= LOW_CYC);
            end
            default: ;
         endcase
      end
   end

   // registered pins; only one latch enable is ever set
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_command_latch_en <= 1'b0;
         o_address_latch_en <= 1'b0;
         o_we_n <= 1'b1;
         o_re_n <= 1'b1;
         o_bus_oe <= 1'b0;
         o_bus <= '0;
         o_ce_n <= 1'b1;
         o_wp_n <= 1'b0;
      end else begin
         o_command_latch_en <= next_cle;
         o_address_latch_en <= next_ale;
         o_we_n <= next_we_n;
         o_re_n <= next_re_n;
         o_bus_oe <= next_oe;
         o_bus <= next_bus;
         o_ce_n <= (state == S_IDLE);
         // protect lifted only for program, copy-back and erase work
         o_wp_n <= (state == S_RUN) && (req.op == nbh_pkg::OP_PROG ||
                   req.op == nbh_pkg::OP_ERASE || req.op == nbh_pkg::OP_COPY);
      end
   end

   // cycle timer: strobe cycles and the wait before busy is trusted
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || state == S_IDLE) begin
         cnt <= 8'h00;
      end else if (act.kind == nbh_pkg::K_BUSY) begin
         if (cnt < WB_CYC) begin
            cnt <= cnt + 8'h01;
         end else if (rb_s) begin
            cnt <= 8'h00;
         end
      end else if (active) begin
         cnt <= cyc_end ? 8'h00 : cnt + 8'h01;
      end
   end

   // sequencer: request, step, byte and word counters
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         state <= S_IDLE;
         req <= '0;
         step <= 3'h0;
         aidx <= 2'h0;
         wcnt <= '0;
         o_req_ready <= 1'b1;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         case (state)
            S_IDLE: begin
               if (i_req_valid && o_req_ready) begin
                  req <= i_req;
                  step <= 3'h0;
                  aidx <= 2'h0;
                  wcnt <= '0;
                  o_req_ready <= 1'b0;
                  state <= S_RUN;
               end
            end
            S_RUN: begin
               case (act.kind)
                  nbh_pkg::K_END: begin
                     o_done <= 1'b1;
                     o_req_ready <= 1'b1;
                     state <= S_IDLE;
                  end
                  // wait for ready/busy to return high
                  nbh_pkg::K_BUSY: begin
                     if (cnt >= WB_CYC && rb_s) begin
                        step <= step + 3'h1;
                     end
                  end
                  nbh_pkg::K_ADDR: begin
                     if (cyc_end) begin
                        if (abyte == act.a_last) begin
                           aidx <= 2'h0;
                           step <= step + 3'h1;
                        end else begin
                           aidx <= aidx + 2'h1;
                        end
                     end
                  end
                  nbh_pkg::K_WDATA, nbh_pkg::K_RDATA: begin
                     if (active && cyc_end) begin
                        if (wcnt >= req.len - 1'b1) begin
                           wcnt <= '0;
                           step <= step + 3'h1;
                        end else begin
                           wcnt <= wcnt + 1'b1;
                        end
                     end
                  end
                  default: begin
                     if (cyc_end) begin
                        step <= step + 3'h1;
                     end
                  end
               endcase
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // read word taken late in the cycle, after the sync lag
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_rd_valid <= 1'b0;
         o_rd_data <= '0;
      end else begin
         o_rd_valid <= active && act.kind == nbh_pkg::K_RDATA && cnt == SAMPLE_AT;
         if (active && act.kind == nbh_pkg::K_RDATA && cnt == SAMPLE_AT) begin
            o_rd_data <= bus_s;
         end
      end
   end
endmodule : nbh_host

// File: nbh_host_chk.sv
`timescale 1ns/1ns
module nbh_host_chk #(
   parameter int DATA_W = 8
) (
   input wire logic i_mclk,              // clock
   input wire logic i_sys_rst,           // reset
   input wire logic o_ce_n,              // select
   input wire logic o_command_latch_en,  // cmd latch
   input wire logic o_address_latch_en,  // addr latch
   input wire logic o_we_n,              // write strobe
   input wire logic o_re_n,              // read strobe
   input wire logic o_wp_n,              // protect
   input wire logic [DATA_W-1:0] o_bus,  // bus out
   input wire logic o_bus_oe             // bus driven
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   logic [2:0] acnt;
   // address cycles since the last command cycle
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         acnt <= 3'h0;
      end else if ($rose(o_we_n) && o_command_latch_en) begin
         acnt <= 3'h0;
      end else if ($rose(o_we_n) && o_address_latch_en) begin
         acnt <= acnt + 3'h1;
      end
   end
   a_cycle_qual: assert property ($rose(o_we_n) |-> !o_ce_n && o_re_n && o_bus_oe)
      else $error("write strobe rose outside a write cycle");
   a_we_width: assert property ($fell(o_we_n) |-> !o_we_n [*4] ##1 o_we_n)
      else $error("write strobe low time wrong");
   a_re_width: assert property ($fell(o_re_n) |-> !o_re_n [*4] ##1 o_re_n)
      else $error("read strobe low time wrong");
   a_read_quiet: assert property (!o_re_n |-> !o_bus_oe && o_we_n && !o_ce_n
      && !o_command_latch_en && !o_address_latch_en)
      else $error("read cycle with bus or latches active");
   a_standby_idle: assert property (o_ce_n |-> !o_bus_oe && o_we_n && o_re_n)
      else $error("strobes or bus active while deselected");
   a_no_both: assert property (!(o_command_latch_en && o_address_latch_en))
      else $error("both latch enables high");
   a_addr_count: assert property ($rose(o_we_n) && o_address_latch_en
      |-> acnt < 3'h4)
      else $error("more than four address cycles");
   a_top_byte: assert property ($rose(o_we_n) && o_address_latch_en && acnt == 3'h3
      |-> o_bus[7:2] == 6'h0)
      else $error("upper lines of last address byte not low");
   a_wp_prog: assert property ($rose(o_we_n) && o_command_latch_en
      && (o_bus[7:0] inside {8'h80, 8'h60, 8'h10, 8'hd0, 8'h8a}) |-> o_wp_n)
      else $error("program or erase code with protect low");
   a_latch_stable: assert property (!o_we_n |=> $stable(o_command_latch_en)
      && $stable(o_address_latch_en) && $stable(o_bus))
      else $error("latches or bus moved during write strobe");
   cover property ($rose(o_we_n) && o_address_latch_en && acnt == 3'h3);
   cover property ($fell(o_re_n));
   cover property ($rose(o_we_n) && !o_command_latch_en && !o_address_latch_en);
endmodule : nbh_host_chk

bind nbh_host nbh_host_chk #(.DATA_W(DATA_W)) u_chk (.i_mclk, .i_sys_rst, .o_ce_n,
   .o_command_latch_en, .o_address_latch_en, .o_we_n, .o_re_n, .o_wp_n, .o_bus, .o_bus_oe);

// File: nbh_host_tb.sv
`timescale 1ns/1ns
module nbh_host_tb;
   logic clk = 0, rst = 1, rv = 0, wv = 0, ce, cl, al, we, re, wp, oe, rr, dn, wr, rdv, rb;
   nbh_pkg::nbh_req_t req = '0;
   logic [7:0] wd = 8'h0, hb, db, bw, rd;
   integer seed = 32'h5c326144, failures = 0, n_compared = 0, wi = 0, wn = 0;
   logic [9:0] eq[$];
   logic [7:0] wq[$], er[$], rq[$];
   always #20 clk = ~clk;
   assign bw = oe ? hb : db;
   nbh_host uut (.i_mclk(clk), .i_sys_rst(rst), .i_req_valid(rv), .i_req(req), .o_req_ready(rr),
      .o_done(dn), .i_wr_valid(wv), .i_wr_data(wd), .o_wr_ready(wr), .o_rd_valid(rdv),
      .o_rd_data(rd), .o_ce_n(ce), .o_command_latch_en(cl), .o_address_latch_en(al),
      .o_we_n(we), .o_re_n(re), .o_wp_n(wp), .o_bus(hb), .o_bus_oe(oe), .i_bus(bw),
      .i_ready_busy_n(rb));
   nbh_dev dev (.i_ce_n(ce), .i_cle(cl), .i_ale(al), .i_we_n(we), .i_re_n(re), .i_wp_n(wp),
      .i_bus(bw), .o_bus(db), .o_rb_n(rb));
   // program words with random gaps; an offered word stays until the fifo takes it
   always @(posedge clk) begin
      if (wv && wr) wi = wi + 1;
      wv <= (wi < wn) && ((wv && !wr) || $random(seed) % 4 != 0);
      wd <= (wi < wn) ? wq[wi] : 8'h00;
   end
   always @(posedge clk) if (rdv === 1'b1) rq.push_back(rd);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   function automatic void pc(logic [1:0] k, logic [7:0] b);
      eq.push_back({k, b});
   endfunction : pc
   function automatic void a3(logic [17:0] r);
      pc(2, r[7:0]);
      pc(2, r[15:8]);
      pc(2, {6'h0, r[17:16]});
   endfunction : a3
   task automatic run(input nbh_pkg::nbh_op_t op, input nbh_pkg::nbh_area_t ar,
      input logic [7:0] c, input logic [17:0] r, input logic [17:0] d, input logic [9:0] n);
      int k;
      eq.delete();
      er.delete();
      rq.delete();
      wq.delete();
      dev.log_q.delete();
      if (op inside {nbh_pkg::OP_READ, nbh_pkg::OP_PROG}) begin
         pc(1, ar == nbh_pkg::AREA_B ? 8'h01 : (ar == nbh_pkg::AREA_C ? 8'h50 : 8'h00));
         if (op == nbh_pkg::OP_PROG) pc(1, 8'h80);
      end
      if (op == nbh_pkg::OP_COPY) pc(1, 8'h00);
      if (op == nbh_pkg::OP_ERASE) pc(1, 8'h60);
      if (op == nbh_pkg::OP_STATUS) pc(1, 8'h70);
      if (op == nbh_pkg::OP_RESET) pc(1, 8'hff);
      if (op == nbh_pkg::OP_SIG) pc(1, 8'h90);
      if (op inside {nbh_pkg::OP_READ, nbh_pkg::OP_PROG, nbh_pkg::OP_COPY, nbh_pkg::OP_SIG})
         pc(2, c);
      if (op inside {nbh_pkg::OP_READ, nbh_pkg::OP_PROG, nbh_pkg::OP_COPY, nbh_pkg::OP_ERASE})
         a3(r);
      if (op == nbh_pkg::OP_COPY) begin
         pc(1, 8'h8a);
         pc(2, c);
         a3(d);
      end
      for (k = 0; k < n; k++) begin
         if (op == nbh_pkg::OP_PROG) wq.push_back(8'($random(seed)));
         if (op == nbh_pkg::OP_PROG) pc(3, wq[k]);
         if (op inside {nbh_pkg::OP_READ, nbh_pkg::OP_SIG}) er.push_back(8'(c + k) ^ 8'h5a);
         if (op == nbh_pkg::OP_STATUS) er.push_back(8'hc0);
      end
      if (op == nbh_pkg::OP_PROG) pc(1, 8'h10);
      if (op == nbh_pkg::OP_ERASE) pc(1, 8'hd0);
      wi = 0;
      wn = wq.size();
      dev.busy_ns = 200 + ($random(seed) & 1023);
      @(posedge clk);
      rv <= 1'b1;
      req <= '{op, ar, c, r, d, n};
      @(posedge clk);
      rv <= 1'b0;
      for (k = 0; k < 20000 && dn !== 1'b1; k++) @(negedge clk);
      if (k == 20000) begin
         failures++;
         report_and_stop();
      end
      chk(dev.log_q.size(), eq.size());
      foreach (eq[i]) chk(dev.log_q[i], eq[i]);
      chk(rq.size(), er.size());
      foreach (er[i]) chk(rq[i], er[i]);
      chk(dev.prot_err, 0);
      chk({rr, rb}, 2'h3);
      chk(dev.ptr_b, 1'h0);
      $display("test %s done", op.name());
   endtask : run
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      run(nbh_pkg::OP_RESET, nbh_pkg::AREA_A, 0, 0, 0, 1);
      run(nbh_pkg::OP_STATUS, nbh_pkg::AREA_A, 0, 0, 0, 2);
      run(nbh_pkg::OP_READ, nbh_pkg::AREA_B, 8'hff, 18'h3ffff, 0, 3);
      run(nbh_pkg::OP_SIG, nbh_pkg::AREA_A, 0, 0, 0, 2);
      run(nbh_pkg::OP_ERASE, nbh_pkg::AREA_A, 0, 18'h2a5c3, 0, 1);
      run(nbh_pkg::OP_PROG, nbh_pkg::AREA_C, 0, 18'h1, 0, 9);
      run(nbh_pkg::OP_COPY, nbh_pkg::AREA_A, 0, 18'h12345, 18'h2abcd, 1);
      repeat (8) run(nbh_pkg::nbh_op_t'($unsigned($random(seed)) % 3),
         nbh_pkg::nbh_area_t'($unsigned($random(seed)) % 3), 8'($random(seed)),
         18'($random(seed)), 0, 10'(1 + $unsigned($random(seed)) % 8));
      report_and_stop();
   end
endmodule : nbh_host_tb

// File: nbh_pkg.sv
package nbh_pkg;
   // clock and bus timing, printed figures in ns
   localparam int CLK_NS = 40;
   localparam int T_STB_LOW_NS = 160;
   localparam int T_STB_HIGH_NS = 80;
   localparam int T_WB_NS = 100;

   // widths of the request fields
   localparam int COL_W = 8;
   localparam int ROW_W = 18;
   localparam int LEN_W = 10;

   // command codes
   localparam logic [7:0] CMD_READ_A = 8'h00;
   localparam logic [7:0] CMD_READ_B = 8'h01;
   localparam logic [7:0] CMD_READ_C = 8'h50;
   localparam logic [7:0] CMD_SIG = 8'h90;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] CMD_PROG = 8'h80;
   localparam logic [7:0] CMD_PROG_GO = 8'h10;
   localparam logic [7:0] CMD_COPY = 8'h8a;
   localparam logic [7:0] CMD_ERASE = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hd0;

   // address byte indices: column, then three row bytes
   localparam logic [1:0] ABYTE_COL = 2'h0;
   localparam logic [1:0] ABYTE_ROW0 = 2'h1;
   localparam logic [1:0] ABYTE_ROW1 = 2'h2;
   localparam logic [1:0] ABYTE_ROW2 = 2'h3;
   // row bits carried by the last address byte
   localparam int ROW_TOP_LSB = 16;

   typedef enum logic [2:0] {
      OP_READ, OP_PROG, OP_ERASE, OP_COPY, OP_STATUS, OP_RESET, OP_SIG
   } nbh_op_t;

   typedef enum logic [1:0] {AREA_A, AREA_B, AREA_C} nbh_area_t;

   typedef struct packed {
      nbh_op_t op;
      nbh_area_t area;
      logic [COL_W-1:0] col;
      logic [ROW_W-1:0] row;
      logic [ROW_W-1:0] dst_row;
      logic [LEN_W-1:0] len;
   } nbh_req_t;

   typedef enum logic [2:0] {K_CMD, K_ADDR, K_WDATA, K_BUSY, K_RDATA, K_END} nbh_kind_t;

   typedef struct packed {
      nbh_kind_t kind;
      logic [7:0] code;
      logic [1:0] a_first;
      logic [1:0] a_last;
      logic dst;
   } nbh_act_t;
endpackage : nbh_pkg
